// ===== src/nvmcs_cfg.svh
// constants for the nvm command sequencer
`ifndef NVMCS_CFG_SVH
`define NVMCS_CFG_SVH
`define NVMCS_CMD_ERASE_ALL     8'h08
`define NVMCS_CMD_ERASE_BLOCK   8'h09
`define NVMCS_CMD_UNSECURE      8'h0B
`define NVMCS_CMD_USER_MARGIN   8'h0D
`define NVMCS_CMD_FIELD_MARGIN  8'h0E
`define NVMCS_CMD_ERASE_VERIFY  8'h10
`define NVMCS_CMD_PROG_EEPROM   8'h11
`define NVMCS_CMD_ERASE_SECTOR  8'h12
`define NVMCS_CMD_PROG_ONCE     8'h07
`define NVMCS_IDX_ERASE_ALL     3'h0
`define NVMCS_IDX_PROG_ONCE     3'h5
`define NVMCS_IDX_PROG_EE_MIN   3'h2
`define NVMCS_IDX_PROG_EE_MAX   3'h5
`define NVMCS_IDX_VERIFY        3'h2
`define NVMCS_IFR_VERSION_ADDR  18'h0_40B6
`define NVMCS_IFR_ONCE_ADDR     18'h0_40C0
`define NVMCS_IFR_ONCE_BYTES    7'h40
`define NVMCS_ONCE_PHRASES      8
`define NVMCS_VERSION_LSB       0
`define NVMCS_VERSION_MSB       3
`define NVMCS_VER_NONE_LO       4'h0
`define NVMCS_VER_NONE_HI       4'hF
`define NVMCS_TIMEBASE_HZ       1000000
`define NVMCS_CLK_HZ            100000000
`define NVMCS_ERASE_TICKS       16'h0014
`define NVMCS_PROG_TICKS        16'h0004
`define NVMCS_VERIFY_TICKS      16'h0002
`define NVMCS_MARGIN_NORMAL     16'h0000
`endif

// ===== src/nvmcs_pkg.sv
// types for the nvm command sequencer
package nvmcs_pkg;
  typedef enum logic [2:0] {
    NVMCS_OP_IDLE,
    NVMCS_OP_READ,
    NVMCS_OP_MARGIN_READ,
    NVMCS_OP_PROGRAM,
    NVMCS_OP_SECTOR_ERASE,
    NVMCS_OP_MASS_ERASE
  } nvmcs_op_t;

  typedef struct packed {
    logic lower_protection_disable;
    logic upper_protection_disable;
    logic program_protection_open;
    logic eeprom_protection_open;
  } nvmcs_prot_t;

  typedef struct packed {
    logic command_complete_flag;
    logic access_error_flag;
    logic protection_violation_flag;
    logic verify_error_status_1;
    logic verify_error_status_0;
  } nvmcs_status_t;

  typedef struct packed {
    logic [2:0]  parameter_index;
    logic [7:0]  command_code;
    logic [15:0] arg1;
    logic [15:0] arg2;
  } nvmcs_cmd_t;
endpackage

// ===== src/nvmcs_timebase.sv
// divider giving one-cycle flash timebase ticks
`timescale 1ns/1ps
module nvmcs_timebase
  import nvmcs_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rstn_i,
  input  wire logic [7:0] timebase_divide_field_i,
  output logic            tick_o
);
  logic [7:0] count;

  // count from divide field; host must set it so ticks land near 1 MHz
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      count  <= 8'h00;
      tick_o <= 1'b0;
    end else if (count >= timebase_divide_field_i) begin
      count  <= 8'h00;
      tick_o <= 1'b1;
    end else begin
      count  <= count + 8'h01;
      tick_o <= 1'b0;
    end
  end
endmodule

// ===== src/nvmcs_ifr.sv
// information area read port and program-once store
`timescale 1ns/1ps
`include "nvmcs_cfg.svh"
module nvmcs_ifr
  import nvmcs_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  input  wire logic        internal_resource_mode_i,
  input  wire logic        rd_en_i,
  input  wire logic [17:0] rd_addr_i,
  input  wire logic [3:0]  version_strap_i,
  input  wire logic        once_wr_i,
  input  wire logic [2:0]  once_phrase_i,
  input  wire logic [15:0] once_data_i,
  input  wire logic        clear_i,
  output logic [2:0]       once_done_o,
  output logic [7:0]       once_used_o,
  output logic [15:0]      rd_data_o
);
  logic [15:0] once_mem [`NVMCS_ONCE_PHRASES];
  logic [7:0]  used;
  logic [17:0] off;

  assign once_used_o = used;
  assign once_done_o = 3'h0;
  assign off = rd_addr_i - `NVMCS_IFR_ONCE_ADDR;

  // one word kept per phrase; a phrase may be written once until clear_i, which the top ties low so erase never clears it
  genvar g;
  for (g = 0; g < `NVMCS_ONCE_PHRASES; g++) begin : g_once
    always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
        once_mem[g] <= 16'hFFFF;
        used[g]     <= 1'b0;
      end else if (clear_i) begin
        once_mem[g] <= 16'hFFFF;
        used[g]     <= 1'b0;
      end else if (once_wr_i && once_phrase_i == 3'(g) && !used[g]) begin
        once_mem[g] <= once_data_i;
        used[g]     <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rd_data_o <= 16'h0000;
    end else if (rd_en_i && internal_resource_mode_i) begin
      if (rd_addr_i == `NVMCS_IFR_VERSION_ADDR) begin
        rd_data_o <= {12'h000, version_strap_i};
      end else if (rd_addr_i >= `NVMCS_IFR_ONCE_ADDR &&
                   off < 18'(`NVMCS_IFR_ONCE_BYTES)) begin
        rd_data_o <= once_mem[off[5:3]];
      end else begin
        rd_data_o <= 16'h0000;
      end
    end else if (rd_en_i) begin
      rd_data_o <= 16'h0000;
    end
  end
endmodule

// ===== src/nvmcs_top.sv
// command sequencer of the embedded nvm controller
// Behaviour
// - code 0x08 erases everything only when all four protection bits set.
// - code 0x09 erases one block; full EEPROM erase needs eeprom open.
// - code 0x0B erases all blocks, verifies erased, then releases security.
// - 0x0D sets user margin; 0x0E sets field margin, special mode only.
// - code 0x10 verifies a word count from an EEPROM address is erased.
// - 0x11 programs one to four EEPROM words; 0x12 erases one sector.
// - flash reads overlap EEPROM margin/program/sector; mass erase only mass.
// - reads after non-normal margin setting count as margin reads.
// - program-once with index other than 101 sets access error.
// - program-once bad or used phrase sets access error, never protection.
// - command unavailable in mode or security state sets access error.
// - verify errors set status 1; uncorrectable verify errors set status 0.
// - erase-all needs parameter index 000, else access error.
// - launch by clearing complete flag; erase, verify, unsecure on pass.
// - complete flag sets again after erase-all and its verify finish.
// - erase-all with any protected region sets violation, no erase.
// - information area readable in internal resource mode.
// - version low nibble; zero and all-ones mean no version.
`timescale 1ns/1ps
`include "nvmcs_cfg.svh"
module nvmcs_top
  import nvmcs_pkg::*;
(
  input  wire logic          clk_i,
  input  wire logic          rstn_i,
  input  wire logic [7:0]    timebase_divide_field_i,
  input  wire nvmcs_prot_t   prot_i,
  input  wire logic          eeprom_fully_open_i,
  input  wire logic          special_mode_i,
  input  wire logic          secured_i,
  input  wire nvmcs_cmd_t    cmd_i,
  input  wire logic          launch_i,
  input  wire logic          pflash_read_i,
  input  wire logic          verify_err_i,
  input  wire logic          verify_uncorr_i,
  input  wire logic          internal_resource_mode_i,
  input  wire logic          ifr_rd_i,
  input  wire logic [17:0]   ifr_addr_i,
  input  wire logic [3:0]    version_strap_i,
  output nvmcs_status_t      status_o,
  output logic               security_released_o,
  output nvmcs_op_t          eeprom_op_o,
  output logic [15:0]        margin_level_o,
  output logic               pflash_read_grant_o,
  output logic               version_present_o,
  output logic [15:0]        ifr_data_o
);
  typedef enum logic [2:0] {
    NVMCS_IDLE,
    NVMCS_CHECK,
    NVMCS_ERASE,
    NVMCS_PROGRAM,
    NVMCS_VERIFY,
    NVMCS_DONE
  } nvmcs_state_t;

  nvmcs_state_t state;
  nvmcs_cmd_t   cmd;
  logic         tick;
  logic [15:0]  ticks_left;
  logic         err_access;
  logic         err_prot;
  logic         verify_fail;
  logic         verify_fail_uc;
  logic         once_wr;
  logic [7:0]   once_used;
  logic         ifr_clear;
  logic         all_open;
  logic         cmd_ok;
  logic         is_mass;

  nvmcs_timebase u_timebase (
    .clk_i                   (clk_i),
    .rstn_i                  (rstn_i),
    .timebase_divide_field_i (timebase_divide_field_i),
    .tick_o                  (tick)
  );

  nvmcs_ifr u_ifr (
    .clk_i                    (clk_i),
    .rstn_i                   (rstn_i),
    .internal_resource_mode_i (internal_resource_mode_i),
    .rd_en_i                  (ifr_rd_i),
    .rd_addr_i                (ifr_addr_i),
    .version_strap_i          (version_strap_i),
    .once_wr_i                (once_wr),
    .once_phrase_i            (cmd.arg1[2:0]),
    .once_data_i              (cmd.arg2),
    .clear_i                  (ifr_clear),
    .once_done_o              (),
    .once_used_o              (once_used),
    .rd_data_o                (ifr_data_o)
  );

  // version nibble holds no version when all-zero or all-one
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      version_present_o <= 1'b0;
    end else begin
      version_present_o <= version_strap_i != `NVMCS_VER_NONE_LO &&
                           version_strap_i != `NVMCS_VER_NONE_HI;
    end
  end

  assign all_open = prot_i.lower_protection_disable &&
                    prot_i.upper_protection_disable &&
                    prot_i.program_protection_open &&
                    prot_i.eeprom_protection_open;
  assign is_mass  = cmd.command_code == `NVMCS_CMD_ERASE_ALL ||
                    cmd.command_code == `NVMCS_CMD_ERASE_BLOCK ||
                    cmd.command_code == `NVMCS_CMD_UNSECURE;

  // validity per command, mode and index
  always_comb begin
    cmd_ok     = 1'b1;
    err_access = 1'b0;
    err_prot   = 1'b0;
    unique case (cmd.command_code)
      `NVMCS_CMD_ERASE_ALL: begin
        err_access = cmd.parameter_index != `NVMCS_IDX_ERASE_ALL;
        err_prot   = !all_open;
      end
      `NVMCS_CMD_ERASE_BLOCK: begin
        err_prot = eeprom_fully_open_i && !prot_i.eeprom_protection_open;
      end
      `NVMCS_CMD_UNSECURE: begin
        err_prot = !all_open;
      end
      `NVMCS_CMD_USER_MARGIN: begin
      end
      `NVMCS_CMD_FIELD_MARGIN: begin
        err_access = !special_mode_i;
      end
      `NVMCS_CMD_ERASE_VERIFY: begin
        err_access = cmd.parameter_index != `NVMCS_IDX_VERIFY;
      end
      `NVMCS_CMD_PROG_EEPROM: begin
        err_access = cmd.parameter_index < `NVMCS_IDX_PROG_EE_MIN ||
                     cmd.parameter_index > `NVMCS_IDX_PROG_EE_MAX;
      end
      `NVMCS_CMD_ERASE_SECTOR: begin
      end
      `NVMCS_CMD_PROG_ONCE: begin
        // protection flag never raised here
        err_access = cmd.parameter_index != `NVMCS_IDX_PROG_ONCE ||
                     cmd.arg1[15:3] != 13'h0000 ||
                     once_used[cmd.arg1[2:0]];
      end
      default: begin
        cmd_ok = 1'b0;
      end
    endcase
    // secured parts accept only erase-all and unsecure
    if (secured_i && !(cmd.command_code == `NVMCS_CMD_ERASE_ALL ||
                       cmd.command_code == `NVMCS_CMD_UNSECURE)) begin
      cmd_ok = 1'b0;
    end
    if (!cmd_ok) begin
      err_access = 1'b1;
    end
  end

  // sequencer: launches only honoured while complete flag is high
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state      <= NVMCS_IDLE;
      cmd        <= '0;
      ticks_left <= 16'h0000;
    end else begin
      unique case (state)
        NVMCS_IDLE: begin
          if (launch_i) begin
            cmd   <= cmd_i;
            state <= NVMCS_CHECK;
          end
        end
        NVMCS_CHECK: begin
          if (err_access || err_prot) begin
            state <= NVMCS_DONE;
          end else if (is_mass || cmd.command_code == `NVMCS_CMD_ERASE_SECTOR) begin
            ticks_left <= `NVMCS_ERASE_TICKS;
            state      <= NVMCS_ERASE;
          end else if (cmd.command_code == `NVMCS_CMD_PROG_EEPROM ||
                       cmd.command_code == `NVMCS_CMD_PROG_ONCE) begin
            ticks_left <= `NVMCS_PROG_TICKS;
            state      <= NVMCS_PROGRAM;
          end else if (cmd.command_code == `NVMCS_CMD_ERASE_VERIFY) begin
            ticks_left <= `NVMCS_VERIFY_TICKS;
            state      <= NVMCS_VERIFY;
          end else begin
            state <= NVMCS_DONE;
          end
        end
        NVMCS_ERASE, NVMCS_PROGRAM: begin
          if (tick && ticks_left == 16'h0000) begin
            ticks_left <= `NVMCS_VERIFY_TICKS;
            state      <= NVMCS_VERIFY;
          end else if (tick) begin
            ticks_left <= ticks_left - 16'h0001;
          end
        end
        NVMCS_VERIFY: begin
          if (tick && ticks_left == 16'h0000) begin
            state <= NVMCS_DONE;
          end else if (tick) begin
            ticks_left <= ticks_left - 16'h0001;
          end
        end
        NVMCS_DONE: begin
          state <= NVMCS_IDLE;
        end
      endcase
    end
  end

  assign once_wr   = state == NVMCS_CHECK && !err_access &&
                     cmd.command_code == `NVMCS_CMD_PROG_ONCE;
  assign ifr_clear = 1'b0;

  // verify result collection over the verify phase
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      verify_fail    <= 1'b0;
      verify_fail_uc <= 1'b0;
    end else if (state == NVMCS_CHECK) begin
      verify_fail    <= 1'b0;
      verify_fail_uc <= 1'b0;
    end else if (state == NVMCS_VERIFY) begin
      verify_fail    <= verify_fail | verify_err_i;
      verify_fail_uc <= verify_fail_uc | verify_uncorr_i;
    end
  end

  // status: flags cleared at launch, raised at check or finish
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      status_o <= '{command_complete_flag: 1'b1, default: 1'b0};
    end else if (state == NVMCS_IDLE && launch_i) begin
      status_o <= '0;
    end else if (state == NVMCS_CHECK) begin
      status_o.access_error_flag         <= err_access;
      status_o.protection_violation_flag <= err_prot && !err_access;
    end else if (state == NVMCS_DONE) begin
      status_o.command_complete_flag <= 1'b1;
      status_o.verify_error_status_1 <= verify_fail;
      status_o.verify_error_status_0 <= verify_fail_uc;
    end
  end

  // security released only by a clean full erase
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      security_released_o <= 1'b0;
    end else if (state == NVMCS_DONE && !verify_fail && !status_o.access_error_flag &&
                 !status_o.protection_violation_flag &&
                 (cmd.command_code == `NVMCS_CMD_ERASE_ALL ||
                  cmd.command_code == `NVMCS_CMD_UNSECURE)) begin
      security_released_o <= 1'b1;
    end
  end

  // margin level kept for read classification
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      margin_level_o <= `NVMCS_MARGIN_NORMAL;
    end else if (state == NVMCS_CHECK && !err_access &&
                 (cmd.command_code == `NVMCS_CMD_USER_MARGIN ||
                  cmd.command_code == `NVMCS_CMD_FIELD_MARGIN)) begin
      margin_level_o <= cmd.arg1;
    end
  end

  // current eeprom operation; non-normal margin makes reads margin reads
  always_comb begin
    unique case (state)
      NVMCS_ERASE: begin
        eeprom_op_o = is_mass ? NVMCS_OP_MASS_ERASE : NVMCS_OP_SECTOR_ERASE;
      end
      NVMCS_PROGRAM: begin
        eeprom_op_o = NVMCS_OP_PROGRAM;
      end
      NVMCS_VERIFY: begin
        eeprom_op_o = margin_level_o != `NVMCS_MARGIN_NORMAL ?
                      NVMCS_OP_MARGIN_READ : NVMCS_OP_READ;
      end
      default: begin
        eeprom_op_o = NVMCS_OP_IDLE;
      end
    endcase
  end

  // flash reads blocked except when idle or alongside margin read, program, sector erase
  assign pflash_read_grant_o = pflash_read_i &&
                               (eeprom_op_o == NVMCS_OP_IDLE ||
                                eeprom_op_o == NVMCS_OP_MARGIN_READ ||
                                eeprom_op_o == NVMCS_OP_PROGRAM ||
                                eeprom_op_o == NVMCS_OP_SECTOR_ERASE);
endmodule

// ===== dv/nvmcs_assertions.sv
// assertion checker for the nvm command sequencer
`timescale 1ns/1ps
`include "nvmcs_cfg.svh"
module nvmcs_checker
  import nvmcs_pkg::*;
(
  input wire logic          clk_i,
  input wire logic          rstn_i,
  input wire nvmcs_prot_t   prot_i,
  input wire logic          special_mode_i,
  input wire logic          secured_i,
  input wire nvmcs_cmd_t    cmd_i,
  input wire logic          launch_i,
  input wire logic          pflash_read_i,
  input wire logic          internal_resource_mode_i,
  input wire logic          ifr_rd_i,
  input wire logic [3:0]    version_strap_i,
  input wire nvmcs_status_t status_o,
  input wire nvmcs_op_t     eeprom_op_o,
  input wire logic          pflash_read_grant_o,
  input wire logic          version_present_o,
  input wire logic [15:0]   ifr_data_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  logic       go;
  logic [7:0] cc;
  logic [2:0] ix;
  // only launches taken while idle count
  assign go = launch_i && status_o.command_complete_flag;
  assign cc = cmd_i.command_code;
  assign ix = cmd_i.parameter_index;
  chk_launch_takes: assert property (go |=> !status_o.command_complete_flag)
    else $error("launch did not start a command");
  chk_erase_index: assert property (
    go && cc == 8'h08 && ix != 3'h0 |-> ##2 status_o.access_error_flag)
    else $error("erase-all index not refused");
  chk_erase_guard: assert property (
    go && cc == 8'h08 && ix == 3'h0 && prot_i != 4'hF
    |-> ##2 (status_o.protection_violation_flag && eeprom_op_o != NVMCS_OP_MASS_ERASE))
    else $error("protected erase-all not stopped");
  chk_field_mode: assert property (
    go && cc == 8'h0E && !special_mode_i |-> ##2 status_o.access_error_flag)
    else $error("field margin accepted in normal mode");
  chk_secured_block: assert property (
    go && secured_i && cc != 8'h08 && cc != 8'h0B |-> ##2 status_o.access_error_flag)
    else $error("command accepted while secured");
  chk_once_index: assert property (
    go && cc == 8'h07 && ix != 3'h5 |-> ##2 status_o.access_error_flag)
    else $error("program-once index not refused");
  chk_once_noviol: assert property (
    go && cc == 8'h07 |-> ##2 !status_o.protection_violation_flag)
    else $error("program-once raised protection flag");
  chk_read_block: assert property (
    pflash_read_grant_o |-> pflash_read_i && eeprom_op_o != NVMCS_OP_MASS_ERASE
    && eeprom_op_o != NVMCS_OP_READ)
    else $error("flash read granted beside a blocking operation");
  chk_read_allow: assert property (
    pflash_read_i && (eeprom_op_o == NVMCS_OP_PROGRAM || eeprom_op_o == NVMCS_OP_SECTOR_ERASE
    || eeprom_op_o == NVMCS_OP_MARGIN_READ) |-> pflash_read_grant_o)
    else $error("allowed flash read refused");
  chk_verify_pair: assert property (
    status_o.verify_error_status_0 |-> status_o.verify_error_status_1)
    else $error("uncorrectable verify error without verify error");
  chk_ifr_closed: assert property (
    ifr_rd_i && !internal_resource_mode_i |=> ifr_data_o == 16'h0000)
    else $error("information area readable outside resource mode");
  chk_version_flag: assert property (
    $past(rstn_i) && $stable(version_strap_i)
    |-> version_present_o == (version_strap_i != 4'h0 && version_strap_i != 4'hF))
    else $error("version presence wrong");
  chk_mass_busy: assert property (
    eeprom_op_o == NVMCS_OP_MASS_ERASE |-> !status_o.command_complete_flag)
    else $error("complete flag high during mass erase");
endmodule
bind nvmcs_top nvmcs_checker nvmcs_checker_inst (.clk_i(clk_i), .rstn_i(rstn_i), .prot_i(prot_i),
  .special_mode_i(special_mode_i), .secured_i(secured_i), .cmd_i(cmd_i), .launch_i(launch_i),
  .pflash_read_i(pflash_read_i), .internal_resource_mode_i(internal_resource_mode_i),
  .ifr_rd_i(ifr_rd_i), .version_strap_i(version_strap_i), .status_o(status_o),
  .eeprom_op_o(eeprom_op_o), .pflash_read_grant_o(pflash_read_grant_o),
  .version_present_o(version_present_o), .ifr_data_o(ifr_data_o));

// ===== dv/nvmcs_host_model.sv
// cpu-side model that sets the divider and launches commands
`timescale 1ns/1ps
module nvmcs_host_model
  import nvmcs_pkg::*;
#(
  parameter logic [7:0] DIV = 8'h63
)
(
  input  wire logic          clk_i,
  input  wire logic          rstn_i,
  input  wire nvmcs_status_t status_i,
  input  wire logic          req_i,
  input  wire nvmcs_cmd_t    req_cmd_i,
  input  wire logic          poke_i,
  output logic [7:0]         div_o,
  output nvmcs_cmd_t         cmd_o,
  output logic               launch_o
);
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      div_o    <= 8'h00;
      cmd_o    <= '0;
      launch_o <= 1'b0;
    end else begin
      div_o    <= DIV;
      launch_o <= 1'b0;
      // parameters wander between launches, only the launch edge is meaningful
      cmd_o    <= ~cmd_o;
      if (req_i && status_i.command_complete_flag && !launch_o) begin
        launch_o <= 1'b1;
        cmd_o    <= req_cmd_i;
      end else if (poke_i) begin
        launch_o <= 1'b1;
      end
    end
  end
endmodule

// ===== dv/tb_top.sv
// self-checking bench for the nvm command sequencer
`timescale 1ns/1ps
`include "nvmcs_cfg.svh"
module tb_top;
  import nvmcs_pkg::*;
  logic          clk_i = 0, rstn_i = 0, full = 0, spec = 0, sec = 0, req = 0, poke = 0;
  logic          launch, pread = 0, verr = 0, vunc = 0, irm = 0, ifr_rd = 0;
  logic          rel = 0, released, grant, vpres;
  logic [7:0]    div;
  logic [17:0]   ifr_addr = 18'h0_0000;
  logic [3:0]    strap = 4'h1;
  logic [15:0]   mrg = 16'h0000, once_dat, rdat, margin, ifr_data;
  nvmcs_prot_t   prot = 4'hF;
  nvmcs_cmd_t    cmd, req_cmd = '0;
  nvmcs_status_t status;
  nvmcs_op_t     op;
  integer        fails = 0, tests_run = 0, seed = 36977;
  logic [7:0]    used = 8'h00;
  logic [2:0]    ph;
  always #5 clk_i = ~clk_i;
  always @(posedge clk_i) pread <= 1'($random(seed));
  nvmcs_host_model nvmcs_host_model_inst (.clk_i(clk_i), .rstn_i(rstn_i), .status_i(status),
    .req_i(req), .req_cmd_i(req_cmd), .poke_i(poke), .div_o(div), .cmd_o(cmd), .launch_o(launch));
  nvmcs_top nvmcs_top_inst (.clk_i(clk_i), .rstn_i(rstn_i), .timebase_divide_field_i(div),
    .prot_i(prot), .eeprom_fully_open_i(full), .special_mode_i(spec), .secured_i(sec),
    .cmd_i(cmd), .launch_i(launch), .pflash_read_i(pread), .verify_err_i(verr),
    .verify_uncorr_i(vunc), .internal_resource_mode_i(irm), .ifr_rd_i(ifr_rd),
    .ifr_addr_i(ifr_addr), .version_strap_i(strap), .status_o(status),
    .security_released_o(released), .eeprom_op_o(op), .margin_level_o(margin),
    .pflash_read_grant_o(grant), .version_present_o(vpres), .ifr_data_o(ifr_data));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %0t got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic reset_dut();
    @(posedge clk_i) rstn_i <= 1'b0;
    repeat (8) @(posedge clk_i);
    rstn_i <= 1'b1;
    @(posedge clk_i);
    #1 rel = 1'b0;
    mrg = 16'h0000;
    used = 8'h00;
    check({11'h000, status}, 16'h0010);
  endtask
  task automatic setk(input logic f, input logic sp);
    @(posedge clk_i);
    full <= f;
    spec <= sp;
    #1;
  endtask
  // reference model: flags and sticky state predicted from the run arguments, mode settings and used phrases
  task automatic run(input logic [7:0] c, input logic [2:0] ix, input logic [3:0] pr,
                     input logic s, input logic [1:0] ve, input logic [15:0] a1);
    logic acc, pv, vf;
    logic [15:0] dat;
    integer n;
    dat = 16'($random(seed));
    acc = s && c != 8'h08 && c != 8'h0B;
    pv  = 1'b0;
    case (c)
      8'h08: if (ix != 3'h0) acc = 1'b1; else pv = (pr != 4'hF);
      8'h09: pv = full && !pr[0];
      8'h0E: acc |= !spec;
      8'h07: acc |= (ix != 3'h5) || used[a1[2:0]];
      8'h10: acc |= (ix != 3'h2);
      8'h11: acc |= (ix < 3'h2) || (ix > 3'h5);
      default: ;
    endcase
    pv &= !acc;
    vf = (c == 8'h08 || c == 8'h0B) && !acc && !pv;
    if (c == 8'h07 && !acc) begin
      used[a1[2:0]] = 1'b1;
      once_dat = dat;
    end
    if ((c == 8'h0D || c == 8'h0E) && !acc) mrg = a1;
    rel |= vf && ve == 2'b00;
    @(posedge clk_i);
    sec <= s;
    prot <= pr;
    {verr, vunc} <= ve;
    req <= 1'b1;
    req_cmd <= '{parameter_index: ix, command_code: c, arg1: a1, arg2: dat};
    @(posedge clk_i) req <= 1'b0;
    repeat (3) @(posedge clk_i);
    n = 0;
    while (status.command_complete_flag !== 1'b1 && n < 5000) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 5000) fails++;
    #1;
    check({11'h000, status}, {11'h001, acc, pv, vf && ve[1], vf && ve[0]});
    check({15'h0000, released}, {15'h0000, rel});
    check(margin, mrg);
  endtask
  task automatic rd(input logic [17:0] a);
    @(posedge clk_i);
    ifr_rd <= 1'b1;
    ifr_addr <= a;
    @(posedge clk_i) ifr_rd <= 1'b0;
    repeat (2) @(posedge clk_i);
    #1 rdat = ifr_data;
  endtask
  initial begin
    // about 2400 cycles per erase, whole run near 20k cycles
    #600000;
    fails++;
    stop_test();
  end
  initial begin
    reset_dut();
    run(8'h08, 3'h1, 4'hF, 1'b0, 2'b00, 16'h0000);
    run(8'h08, 3'h0, 4'hE, 1'b0, 2'b00, 16'h0000);
    run(8'h08, 3'h0, 4'hF, 1'b1, 2'b11, 16'h0000);
    run(8'h09, 3'h1, 4'hF, 1'b1, 2'b00, 16'h0000);
    fork
      run(8'h08, 3'h0, 4'hF, 1'b0, 2'b00, 16'h0000);
      begin
        repeat (12) @(posedge clk_i);
        poke <= 1'b1;
        @(posedge clk_i) poke <= 1'b0;
      end
    join
    reset_dut();
    run(8'h0B, 3'h0, 4'hF, 1'b0, 2'b10, 16'h0000);
    run(8'h0B, 3'h0, 4'hF, 1'b0, 2'b00, 16'h0000);
    setk(1'b1, 1'b0);
    run(8'h09, 3'h1, 4'hE, 1'b0, 2'b00, 16'h0000);
    run(8'h09, 3'h1, 4'hF, 1'b0, 2'b00, 16'h0000);
    run(8'h12, 3'h1, 4'hF, 1'b0, 2'b00, 16'h0000);
    for (int i = 0; i < 8; i++) run(8'h11, 3'(i), 4'hF, 1'b0, 2'b00, 16'h0000);
    run(8'h10, 3'h3, 4'hF, 1'b0, 2'b00, 16'h0000);
    run(8'h10, 3'h2, 4'hF, 1'b0, 2'b00, 16'h0000);
    run(8'h0D, 3'h1, 4'hF, 1'b0, 2'b00, 16'($random(seed)) | 16'h0001);
    run(8'h0E, 3'h1, 4'hF, 1'b0, 2'b00, 16'h0003);
    setk(1'b0, 1'b1);
    run(8'h0E, 3'h1, 4'hF, 1'b0, 2'b00, 16'h0003);
    run(8'h10, 3'h2, 4'hF, 1'b0, 2'b00, 16'h0000);
    run(8'h0D, 3'h1, 4'hF, 1'b0, 2'b00, 16'h0000);
    ph = 3'($random(seed));
    run(8'h07, 3'h4, 4'hF, 1'b0, 2'b00, {13'h0000, ph});
    run(8'h07, 3'h5, 4'hF, 1'b0, 2'b00, {13'h0000, ph});
    run(8'h07, 3'h5, 4'hF, 1'b0, 2'b00, {13'h0000, ph});
    @(posedge clk_i) irm <= 1'b1;
    rd(18'(`NVMCS_IFR_ONCE_ADDR + 8 * ph));
    check(rdat, once_dat);
    foreach (rdat[i]) if (i < 4) begin
      @(posedge clk_i) strap <= {i[1], i[0], i[0], i[1]};
      rd(`NVMCS_IFR_VERSION_ADDR);
      check({12'h000, rdat[3:0]}, {12'h000, strap});
      check({15'h0000, vpres}, {15'h0000, strap != 4'h0 && strap != 4'hF});
    end
    @(posedge clk_i) irm <= 1'b0;
    strap <= 4'h5;
    rd(`NVMCS_IFR_VERSION_ADDR);
    check(rdat, 16'h0000);
    stop_test();
  end
endmodule
